/* src/ebofsm_top.v */
// External bus ownership state machine with three-wire request output.
// Assumes all inputs synchronous to core_clk; pins are active low.
`timescale 1ns/1ps
`include "ebofsm_map.vh"

module ebofsm_top #(
  parameter BEAT_W = `EBO_BEAT_W
) (
  // Clocking and reset
  input  wire              core_clk,
  input  wire              rst,
  input  wire              clk_en,
  input  wire              reset_in_n,
  input  wire              wdog_reset,
  // Arbitration pins
  input  wire              bus_grant_n,
  output reg               bus_driven_n,
  output reg               bus_request_n,
  // Configuration
  input  wire              bus_lock_bit,
  input  wire              three_wire_mode,
  // Core side request
  input  wire              int_bus_req,
  input  wire [BEAT_W-1:0] req_beats,
  output reg               xfer_go,
  // Bus termination inputs
  input  wire              transfer_ack_n,
  input  wire              transfer_error_ack_n,
  // Drive controls
  output reg               transfer_start_n,
  output reg               transfer_start_oe,
  output reg               addr_ctl_oe,
  output reg               mem_strobe_en,
  output reg               owner_state_expl,
  output reg               owner_state_impl
);

  // --------------------------------------------------------------------
  // State machine encodings
  // --------------------------------------------------------------------
  localparam [`EBO_ST_W-1:0] ST_RESET = `EBO_ST_RESET;
  localparam [`EBO_ST_W-1:0] ST_EMOWN = `EBO_ST_EMOWN;
  localparam [`EBO_ST_W-1:0] ST_IMPL  = `EBO_ST_IMPL;
  localparam [`EBO_ST_W-1:0] ST_EXPL  = `EBO_ST_EXPL;

  reg  [`EBO_ST_W-1:0] state_q;
  reg  [`EBO_ST_W-1:0] state_d;
  reg                  pend_q;
  reg                  pend_d;
  reg                  start_d;
  wire                 any_reset;
  wire                 granted;
  wire                 in_prog;
  wire                 eoc;
  wire                 want;

  // --------------------------------------------------------------------
  // Input qualification
  // --------------------------------------------------------------------
  assign any_reset = rst || (reset_in_n == `EBO_PIN_ASSERT) || wdog_reset;
  assign granted   = (bus_grant_n == `EBO_PIN_ASSERT);
  // A request counts until its transfer has actually started
  assign want      = int_bus_req || pend_q;

  // --------------------------------------------------------------------
  // Transfer tracking
  // --------------------------------------------------------------------
  ebo_xfer_track #(
    .BEAT_W (BEAT_W)
  ) u_track (
    .core_clk             (core_clk),
    .rst                  (any_reset),
    .clk_en               (clk_en),
    .xfer_start           (start_d),
    .xfer_beats           (req_beats),
    .transfer_ack_n       (transfer_ack_n),
    .transfer_error_ack_n (transfer_error_ack_n),
    .in_progress          (in_prog),
    .end_of_cycle         (eoc)
  );

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------
  // Same machine for two- and three-wire modes
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RESET: begin
        state_d = granted ? ST_IMPL : ST_EMOWN;
      end
      ST_IMPL: begin
        if (!granted)
          state_d = ST_EMOWN;
        else if (bus_lock_bit || want)
          state_d = ST_EXPL;
      end
      ST_EXPL: begin
        // Release waits for the last beat of a burst series
        if (!granted && !bus_lock_bit && (!in_prog || eoc))
          state_d = ST_EMOWN;
      end
      ST_EMOWN: begin
        if (granted)
          state_d = (bus_lock_bit || want) ? ST_EXPL : ST_IMPL;
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Transfer start decision
  // --------------------------------------------------------------------
  // Start only where next state is explicit, so bus-driven and start
  // rise together; grant seen now gives a start one edge later
  always @* begin
    start_d = 1'b0;
    if (!any_reset && (state_d == ST_EXPL) && want && (!in_prog || eoc)) begin
      // Lock alone never starts a transfer
      start_d = 1'b1;
    end
  end

  // Pending request latch: clear wins over set when start and a new
  // request coincide, because the start serves that int_bus_req
  always @* begin
    pend_d = pend_q;
    if (start_d)
      pend_d = 1'b0;
    if (int_bus_req && !start_d)
      pend_d = 1'b1;
  end

  // --------------------------------------------------------------------
  // State and output registers
  // --------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (any_reset) begin
      state_q           <= ST_RESET;
      pend_q            <= 1'b0;
      bus_driven_n      <= `EBO_PIN_NEGATE;
      bus_request_n     <= `EBO_PIN_NEGATE;
      xfer_go           <= 1'b0;
      transfer_start_n  <= `EBO_PIN_NEGATE;
      transfer_start_oe <= 1'b0;
      addr_ctl_oe       <= 1'b0;
      mem_strobe_en     <= 1'b1;
      owner_state_expl  <= 1'b0;
      owner_state_impl  <= 1'b0;
    end else if (clk_en) begin
      state_q          <= state_d;
      pend_q           <= pend_d;
      // Bus driven only in explicit ownership; holds while granted
      bus_driven_n     <= (state_d == ST_EXPL) ? `EBO_PIN_ASSERT
                                               : `EBO_PIN_NEGATE;
      addr_ctl_oe      <= (state_d == ST_EXPL);
      transfer_start_oe <= (state_d == ST_EXPL);
      transfer_start_n <= start_d ? `EBO_PIN_ASSERT : `EBO_PIN_NEGATE;
      xfer_go          <= start_d;
      // In three-wire mode the request pin follows the pending request,
      // dropped at the start edge; both pins always driven, never floated
      bus_request_n    <= (three_wire_mode && pend_d) ? `EBO_PIN_ASSERT
                                                      : `EBO_PIN_NEGATE;
      // Memory strobes stay available in every ownership state
      mem_strobe_en    <= 1'b1;
      owner_state_expl <= (state_d == ST_EXPL);
      owner_state_impl <= (state_d == ST_IMPL);
    end
  end

endmodule // ebofsm_top

/* src/ebofsm_map.vh */
// Constants for the external bus ownership state machine.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef EBOFSM_MAP_VH
`define EBOFSM_MAP_VH

// ----------------------------------------------------------------------
// State codes, one-hot
// ----------------------------------------------------------------------
`define EBO_ST_W        4
`define EBO_ST_RESET    4'h1
`define EBO_ST_EMOWN    4'h2
`define EBO_ST_IMPL     4'h4
`define EBO_ST_EXPL     4'h8

// ----------------------------------------------------------------------
// Pin levels (all arbitration pins are active low)
// ----------------------------------------------------------------------
`define EBO_PIN_ASSERT  1'h0
`define EBO_PIN_NEGATE  1'h1

// ----------------------------------------------------------------------
// Transfer tracking
// ----------------------------------------------------------------------
`define EBO_BEAT_W      8
`define EBO_BEAT_ONE    8'h01
`define EBO_BEAT_ZERO   8'h00

`endif

/* src/ebo_xfer_track.v */
// Transfer tracker: marks when a bus cycle (burst or burst-inhibited
// series counted as one) is in progress and when it ends.
// Assumes start and beat count come from the device's bus controller.
`timescale 1ns/1ps
`include "ebofsm_map.vh"

module ebo_xfer_track #(
  parameter BEAT_W = `EBO_BEAT_W
) (
  // Clocking
  input  wire              core_clk,
  input  wire              rst,
  input  wire              clk_en,
  // Cycle events
  input  wire              xfer_start,
  input  wire [BEAT_W-1:0] xfer_beats,
  input  wire              transfer_ack_n,
  input  wire              transfer_error_ack_n,
  // Status
  output wire              in_progress,
  output wire              end_of_cycle
);

  reg  [BEAT_W-1:0] left_q;
  reg  [BEAT_W-1:0] left_d;
  wire              term;
  wire              busy;

  // Normal or error termination ends one transfer
  assign term = (transfer_ack_n == `EBO_PIN_ASSERT) ||
                (transfer_error_ack_n == `EBO_PIN_ASSERT);
  assign busy = (left_q != `EBO_BEAT_ZERO);
  // The cycle stays in progress until its last beat or an error ack
  assign in_progress  = busy;
  // An error ack ends the whole series, so it closes the cycle at any beat
  assign end_of_cycle = busy && ((transfer_error_ack_n == `EBO_PIN_ASSERT) ||
                        (term && (left_q == `EBO_BEAT_ONE)));

  // Beats outstanding; an error ends the whole series at once
  always @* begin
    left_d = left_q;
    if (busy && term) begin
      if (transfer_error_ack_n == `EBO_PIN_ASSERT)
        left_d = `EBO_BEAT_ZERO;
      else
        left_d = left_q - `EBO_BEAT_ONE;
    end else if (!busy && xfer_start) begin
      left_d = (xfer_beats == `EBO_BEAT_ZERO) ? `EBO_BEAT_ONE : xfer_beats;
    end
  end

  // Beat counter register
  always @(posedge core_clk) begin
    if (rst)
      left_q <= `EBO_BEAT_ZERO;
    else if (clk_en)
      left_q <= left_d;
  end

endmodule // ebo_xfer_track

/* tb/ebofsm_props.sv */
// Checker for the ownership state machine pins.
// Assumes it is bound to ebofsm_top; one clock.
`timescale 1ns/1ps
module ebofsm_props (
  // Clock and resets
  input wire core_clk, rst, clk_en, reset_in_n, wdog_reset,
  // Arbitration and config
  input wire bus_grant_n, bus_driven_n, bus_request_n,
  input wire bus_lock_bit, three_wire_mode, int_bus_req,
  // Drive controls
  input wire xfer_go, transfer_start_n, transfer_start_oe,
  input wire addr_ctl_oe, mem_strobe_en, owner_state_expl, owner_state_impl
);
  // ----
  // Properties
  // ----
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst || !reset_in_n || wdog_reset);

  a_reset_quiet: assert property (disable iff (1'b0)
    (rst || !reset_in_n || wdog_reset) |=> bus_driven_n && transfer_start_n && !addr_ctl_oe)
    else $error("bus driven in reset");
  a_drive_match: assert property (owner_state_expl == !bus_driven_n &&
    addr_ctl_oe == owner_state_expl && transfer_start_oe == addr_ctl_oe)
    else $error("drive enables off state");
  a_start_with_bd: assert property (!transfer_start_n |->
    !bus_driven_n && xfer_go) else $error("start without bus driven");
  a_start_pulse: assert property (!transfer_start_n |=> transfer_start_n)
    else $error("start longer than a cycle");
  a_lock_takes: assert property (clk_en && owner_state_impl && !bus_grant_n &&
    bus_lock_bit |=> !bus_driven_n) else $error("lock not taken");
  a_hold_owner: assert property (clk_en && owner_state_expl &&
    (!bus_grant_n || bus_lock_bit) |=> owner_state_expl) else $error("explicit dropped");
  a_grant_lost: assert property (clk_en && owner_state_impl && bus_grant_n
    |=> !owner_state_impl && !owner_state_expl) else $error("implicit kept");
  a_no_grant_entry: assert property (clk_en && !owner_state_expl && bus_grant_n
    |=> !owner_state_expl) else $error("explicit without grant");
  a_req_latch: assert property (clk_en && three_wire_mode && int_bus_req
    |=> bus_request_n != transfer_start_n) else $error("request not shown");
  a_two_wire_idle: assert property (clk_en && !three_wire_mode |=> bus_request_n)
    else $error("request in two-wire");
  a_strobes_on: assert property (mem_strobe_en) else $error("strobes off");
endmodule // ebofsm_props

bind ebofsm_top ebofsm_props ebofsm_props_i (.core_clk, .rst, .clk_en, .reset_in_n,
  .wdog_reset, .bus_grant_n, .bus_driven_n, .bus_request_n, .bus_lock_bit,
  .three_wire_mode, .int_bus_req, .xfer_go, .transfer_start_n, .transfer_start_oe,
  .addr_ctl_oe, .mem_strobe_en, .owner_state_expl, .owner_state_impl);

/* tb/ebofsm_arb.sv */
// Far side: arbiter granting the bus, slave acking each beat.
// Assumes the bench commands grant; acks follow each start.
`timescale 1ns/1ps
module ebofsm_arb (
  // Clock and commands
  input  wire       core_clk,
  input  wire       rst,
  input  wire       give,
  input  wire       err_mode,
  input  wire [7:0] nbeats,
  // Device pins
  input  wire       transfer_start_n,
  output reg        bus_grant_n,
  output reg        transfer_ack_n,
  output reg        transfer_error_ack_n
);
  reg [7:0] left_q;
  // ----
  // Grant on command only; bench withholds it while others drive
  // ----
  always @(posedge core_clk) begin
    bus_grant_n          <= rst | ~give;
    transfer_ack_n       <= 1'h1;
    transfer_error_ack_n <= 1'h1;
    if (rst)
      left_q <= 8'h00;
    else if (!transfer_start_n)
      left_q <= nbeats;
    else if (left_q != 8'h00) begin
      // Error ack ends the series at once
      transfer_error_ack_n <= ~err_mode;
      transfer_ack_n       <= err_mode;
      left_q               <= err_mode ? 8'h00 : left_q - 8'h01;
    end
  end
endmodule // ebofsm_arb

/* tb/testbench.sv */
// Bench for ebofsm_top with arbiter model.
// Assumes 25 MHz core_clk; inputs driven by NBA at rising edge.
`timescale 1ns/1ps
module testbench;
  reg       core_clk = 1'h0, rst = 1'h1, reset_in_n = 1'h1, wdog_reset = 1'h0;
  reg       give = 1'h1, err_mode = 1'h0, bus_lock_bit = 1'h0;
  reg       three_wire_mode = 1'h0, int_bus_req = 1'h0;
  reg [7:0] req_beats = 8'h01;
  wire      bus_grant_n, bus_driven_n, bus_request_n, xfer_go, transfer_ack_n;
  wire      transfer_error_ack_n, transfer_start_n, owner_state_expl, owner_state_impl;
  wire      addr_ctl_oe;
  integer   num_errors = 0, checks_done = 0, cyc = 0, i;

  initial forever #20 core_clk = ~core_clk;
  // Cut a hang short
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc > 600) begin
      num_errors = num_errors + 1;
      test_done;
    end
  end

  ebofsm_top ebofsm_top_i (.core_clk, .rst, .clk_en(1'h1), .reset_in_n, .wdog_reset,
    .bus_grant_n, .bus_driven_n, .bus_request_n, .bus_lock_bit, .three_wire_mode,
    .int_bus_req, .req_beats, .xfer_go, .transfer_ack_n, .transfer_error_ack_n,
    .transfer_start_n, .transfer_start_oe(), .addr_ctl_oe, .mem_strobe_en(),
    .owner_state_expl, .owner_state_impl);
  ebofsm_arb ebofsm_arb_i (.core_clk, .rst, .give, .err_mode, .nbeats(req_beats),
    .transfer_start_n, .bus_grant_n, .transfer_ack_n, .transfer_error_ack_n);

  task test_done;
    begin
      if (num_errors == 0 && checks_done > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Wait edges, then let outputs settle
  task tk(input integer n);
    begin
      repeat (n) @(posedge core_clk);
      #1;
    end
  endtask
  // One-cycle request; the design latches it as pending unless a start serves it in the same cycle
  task pulse_req;
    begin
      @(posedge core_clk) int_bus_req <= 1'h1;
      @(posedge core_clk) int_bus_req <= 1'h0;
      #1;
    end
  endtask

  task t_reset;
    begin
      tk(3);
      chk(owner_state_impl, 8'h01);
      @(posedge core_clk) wdog_reset <= 1'h1;
      tk(1);
      chk({owner_state_impl, bus_driven_n}, 8'h01);
      @(posedge core_clk) wdog_reset <= 1'h0;
      tk(2);
      @(posedge core_clk) give <= 1'h0;
      tk(3);
      chk({owner_state_impl, owner_state_expl}, 8'h00);
      @(posedge core_clk) reset_in_n <= 1'h0;
      give <= 1'h1;
      tk(3);
      chk(owner_state_impl, 8'h00);
      @(posedge core_clk) reset_in_n <= 1'h1;
      tk(2);
      chk(owner_state_impl, 8'h01);
    end
  endtask
  // Request start, grant holds ownership, then release
  task t_req;
    begin
      pulse_req;
      chk({transfer_start_n, bus_driven_n, xfer_go, bus_request_n}, 8'h03);
      tk(6);
      chk({bus_driven_n, addr_ctl_oe, transfer_start_n}, 8'h03);
      @(posedge core_clk) give <= 1'h0;
      tk(3);
      chk({bus_driven_n, owner_state_expl}, 8'h02);
    end
  endtask
  // Three-beat series, grant withdrawn early; normal then error end
  task t_burst;
    for (i = 0; i < 2; i = i + 1) begin
      @(posedge core_clk) err_mode <= i[0];
      req_beats <= 8'h03;
      give <= 1'h1;
      tk(3);
      pulse_req;
      @(posedge core_clk) give <= 1'h0;
      tk(i ? 1 : 3);
      chk(bus_driven_n, 8'h00);
      tk(1);
      chk(bus_driven_n, 8'h01);
    end
  endtask
  task t_lock;
    begin
      @(posedge core_clk) give <= 1'h1;
      err_mode <= 1'h0;
      tk(3);
      @(posedge core_clk) bus_lock_bit <= 1'h1;
      tk(1);
      chk({bus_driven_n, transfer_start_n, addr_ctl_oe}, 8'h03);
      @(posedge core_clk) give <= 1'h0;
      tk(4);
      chk(bus_driven_n, 8'h00);
      @(posedge core_clk) bus_lock_bit <= 1'h0;
      tk(1);
      chk({bus_driven_n, addr_ctl_oe}, 8'h02);
    end
  endtask
  // Three-wire request held until the start
  task t_br;
    begin
      @(posedge core_clk) three_wire_mode <= 1'h1;
      req_beats <= 8'h01;
      pulse_req;
      chk({bus_request_n, bus_driven_n}, 8'h01);
      @(posedge core_clk) give <= 1'h1;
      tk(1);
      chk(bus_request_n, 8'h00);
      tk(1);
      chk({transfer_start_n, bus_driven_n, bus_request_n}, 8'h01);
      tk(5);
    end
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'h0;
    t_reset;
    t_req;
    t_burst;
    t_lock;
    t_br;
    test_done;
  end
endmodule // testbench
